// file: hdl/sip_packer.sv
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module sip_packer #(
	parameter int NUM_SLAVES = 32,
	parameter bit LARGE_VARIANT = 1'b1
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Avalon-MM slave.
	input wire logic [6:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Local terminal state.
	input wire logic [7:0] test_ok_i,
	input wire logic [1:0] test_open_ok_i,
	input wire logic [39:0] input_eval_i,
	input wire logic [7:0] output_on_i,
	// Safety master link.
	input wire logic [NUM_SLAVES-1:0] slave_rx_i,
	output logic [NUM_SLAVES-1:0] slave_active_o,
	output logic [NUM_SLAVES-1:0] slave_safe_o,
	// Packed data.
	output sip_pkg::sip_image_t image_o,
	output logic [31:0] tag_bytes_o,
	// Interrupt.
	output logic irq_o
);

	localparam int IRQ_W = sip_pkg::IRQ_W;

	sip_pkg::sip_avl_req_t req;
	sip_pkg::sip_image_t next_image;
	sip_pkg::sip_tag_t tag_type;
	logic [31:0] tag_value;
	logic [31:0] next_tag_bytes;
	logic [NUM_SLAVES-1:0] slv_registered;
	logic [NUM_SLAVES-1:0] slv_configured;
	logic [NUM_SLAVES-1:0] slv_timeout;
	logic [NUM_SLAVES-1:0] next_expire;
	logic [15:0] epi;
	logic [15:0] wd_count [NUM_SLAVES];
	logic [6:0] tick_count;
	logic tick;
	logic ctrl_enable;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_event;
	logic [15:0] test_prev;
	logic done;
	logic wr_done;
	logic rd_done;
	logic [31:0] next_readdata;

	localparam logic [6:0] TICK_LAST = 7'(sip_pkg::TICK_CYCLES - 1);

	// Bundle the bus request and mark the completing edge.
	assign req = '{read: avs_read_i, write: avs_write_i, address: avs_address_i, writedata: avs_writedata_i};
	assign done = (req.read | req.write) & ~avs_waitrequest_o;
	assign wr_done = done & req.write;
	assign rd_done = done & req.read;

	// Build the status bytes; reserved bits and absent bytes stay at zero.
	always_comb begin
		next_image = '0;
		next_image.test_lo[sip_pkg::TEST_STATE_W-1:0] = test_ok_i[3:0];
		next_image.test_lo[sip_pkg::TEST_OPEN_BIT] = test_open_ok_i[0];
		if (LARGE_VARIANT) begin
			next_image.test_hi[sip_pkg::TEST_STATE_W-1:0] = test_ok_i[7:4];
			next_image.test_hi[sip_pkg::TEST_OPEN_BIT] = test_open_ok_i[1];
		end
		// The evaluated result is used so paired channels and errors show as logic decides.
		next_image.in_mon[0] = input_eval_i[7:0];
		next_image.in_mon[1] = input_eval_i[15:8];
		if (LARGE_VARIANT) begin
			next_image.in_mon[2] = input_eval_i[23:16];
			next_image.in_mon[3] = input_eval_i[31:24];
			next_image.in_mon[4] = input_eval_i[39:32];
		end
		next_image.out_mon = output_on_i;
	end

	// Register the local image every cycle.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			image_o <= '0;
		end else begin
			image_o <= next_image;
		end
	end

	// Pack the user tag by its type, zero-filling unused bits.
	always_comb begin
		next_tag_bytes = '0;
		case (tag_type)
			sip_pkg::SIP_TAG_BOOL: next_tag_bytes[0] = tag_value[0];
			sip_pkg::SIP_TAG_BYTE: next_tag_bytes[7:0] = tag_value[7:0];
			sip_pkg::SIP_TAG_WORD: next_tag_bytes[15:0] = tag_value[15:0];
			sip_pkg::SIP_TAG_DWORD: next_tag_bytes = tag_value;
			default: next_tag_bytes = '0;
		endcase
	end

	// Drive the packed tag, byte 0 in bits 7..0.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tag_bytes_o <= '0;
		end else begin
			tag_bytes_o <= next_tag_bytes;
		end
	end

	// Software-written configuration registers.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tag_type <= sip_pkg::SIP_TAG_BOOL;
			tag_value <= '0;
			slv_registered <= '0;
			slv_configured <= '0;
			epi <= sip_pkg::EPI_RESET;
			irq_mask <= sip_pkg::IRQ_MASK_RESET;
			ctrl_enable <= 1'b0;
		end else if (wr_done) begin
			case (req.address)
				sip_pkg::ADDR_TAG_TYPE: tag_type <= sip_pkg::sip_tag_t'(req.writedata[1:0]);
				sip_pkg::ADDR_TAG_VALUE: tag_value <= req.writedata;
				sip_pkg::ADDR_SLV_REG: slv_registered <= req.writedata[NUM_SLAVES-1:0];
				sip_pkg::ADDR_SLV_CFG: slv_configured <= req.writedata[NUM_SLAVES-1:0];
				sip_pkg::ADDR_EPI: epi <= req.writedata[15:0];
				sip_pkg::ADDR_IRQ_MASK: irq_mask <= req.writedata[IRQ_W-1:0];
				sip_pkg::ADDR_CTRL: ctrl_enable <= req.writedata[sip_pkg::CTRL_ENABLE_BIT];
				default: ;
			endcase
		end
	end

	// Microsecond tick for the watchdogs.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tick_count <= '0;
			tick <= 1'b0;
		end else if (tick_count == TICK_LAST) begin
			tick_count <= '0;
			tick <= 1'b1;
		end else begin
			tick_count <= tick_count + 7'h01;
			tick <= 1'b0;
		end
	end

	// A watchdog expires when a tick finds the count at or above the interval.
	always_comb begin
		for (int i = 0; i < NUM_SLAVES; i++) begin
			next_expire[i] = slave_active_o[i] & tick & ~slave_rx_i[i] & (wd_count[i] >= epi);
		end
	end

	// Per-slave watchdog counters, reloaded by every received packet.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < NUM_SLAVES; i++) begin
				wd_count[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_SLAVES; i++) begin
				if (!slave_active_o[i] || slave_rx_i[i]) begin
					wd_count[i] <= '0;
				end else if (tick && wd_count[i] != 16'hFFFF) begin
					wd_count[i] <= wd_count[i] + 16'h0001;
				end
			end
		end
	end

	// Connection state: opened by hardware once allowed, dropped on timeout until a restart write.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			slave_active_o <= '0;
			slave_safe_o <= '1;
			slv_timeout <= '0;
		end else begin
			for (int i = 0; i < NUM_SLAVES; i++) begin
				if (next_expire[i]) begin
					slave_active_o[i] <= 1'b0;
					slave_safe_o[i] <= 1'b1;
					slv_timeout[i] <= 1'b1;
				end else begin
					// Opening needs no program action once enabled, registered and configured, with no timeout pending.
					slave_active_o[i] <= ctrl_enable & slv_registered[i] & slv_configured[i] & ~slv_timeout[i];
					slave_safe_o[i] <= ~(ctrl_enable & slv_registered[i] & slv_configured[i] & ~slv_timeout[i]);
					if (wr_done && req.address == sip_pkg::ADDR_SLV_RESTART && req.writedata[i]) begin
						slv_timeout[i] <= 1'b0;
					end
				end
			end
		end
	end

	// Events: any watchdog expiry, any test-output status bit going to error.
	always_comb begin
		irq_event = '0;
		irq_event[sip_pkg::IRQ_TIMEOUT_BIT] = |next_expire;
		irq_event[sip_pkg::IRQ_FAULT_BIT] = |(test_prev & ~{image_o.test_hi, image_o.test_lo});
	end

	// Sticky status cleared by a read; a new event wins over the clear.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			test_prev <= '0;
			irq_status <= '0;
		end else begin
			test_prev <= {image_o.test_hi, image_o.test_lo};
			if (rd_done && req.address == sip_pkg::ADDR_IRQ_STATUS) begin
				irq_status <= irq_event;
			end else begin
				irq_status <= irq_status | irq_event;
			end
		end
	end

	// Level interrupt from masked status.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |((irq_status | irq_event) & irq_mask);
		end
	end

	// Read multiplexer; unmapped addresses read zero.
	always_comb begin
		next_readdata = '0;
		case (req.address)
			sip_pkg::ADDR_TEST_LO: next_readdata[7:0] = image_o.test_lo;
			sip_pkg::ADDR_TEST_HI: next_readdata[7:0] = image_o.test_hi;
			sip_pkg::ADDR_IN_MON0: next_readdata[7:0] = image_o.in_mon[0];
			sip_pkg::ADDR_IN_MON1: next_readdata[7:0] = image_o.in_mon[1];
			sip_pkg::ADDR_IN_MON2: next_readdata[7:0] = image_o.in_mon[2];
			sip_pkg::ADDR_IN_MON3: next_readdata[7:0] = image_o.in_mon[3];
			sip_pkg::ADDR_IN_MON4: next_readdata[7:0] = image_o.in_mon[4];
			sip_pkg::ADDR_OUT_MON: next_readdata[7:0] = image_o.out_mon;
			sip_pkg::ADDR_TAG_TYPE: next_readdata[1:0] = tag_type;
			sip_pkg::ADDR_TAG_VALUE: next_readdata = tag_value;
			sip_pkg::ADDR_TAG_PACKED: next_readdata = tag_bytes_o;
			sip_pkg::ADDR_SLV_REG: next_readdata[NUM_SLAVES-1:0] = slv_registered;
			sip_pkg::ADDR_SLV_CFG: next_readdata[NUM_SLAVES-1:0] = slv_configured;
			sip_pkg::ADDR_SLV_ACTIVE: next_readdata[NUM_SLAVES-1:0] = slave_active_o;
			sip_pkg::ADDR_SLV_TIMEOUT: next_readdata[NUM_SLAVES-1:0] = slv_timeout;
			sip_pkg::ADDR_EPI: next_readdata[15:0] = epi;
			sip_pkg::ADDR_IRQ_STATUS: next_readdata[IRQ_W-1:0] = irq_status | irq_event;
			sip_pkg::ADDR_IRQ_MASK: next_readdata[IRQ_W-1:0] = irq_mask;
			sip_pkg::ADDR_CTRL: next_readdata[sip_pkg::CTRL_ENABLE_BIT] = ctrl_enable;
			default: next_readdata = '0;
		endcase
	end

	// One wait cycle per access: waitrequest drops for exactly the completing cycle.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= '0;
		end else if (done) begin
			avs_waitrequest_o <= 1'b1;
		end else if (req.read || req.write) begin
			avs_waitrequest_o <= 1'b0;
			avs_readdata_o <= next_readdata;
		end
	end

endmodule : sip_packer

`default_nettype wire

// file: hdl/sip_pkg.sv
package sip_pkg;

	// Byte addresses of the register words on the Avalon-MM slave.
	localparam logic [6:0] ADDR_TEST_LO = 7'h00;
	localparam logic [6:0] ADDR_TEST_HI = 7'h04;
	localparam logic [6:0] ADDR_IN_MON0 = 7'h08;
	localparam logic [6:0] ADDR_IN_MON1 = 7'h0C;
	localparam logic [6:0] ADDR_IN_MON2 = 7'h10;
	localparam logic [6:0] ADDR_IN_MON3 = 7'h14;
	localparam logic [6:0] ADDR_IN_MON4 = 7'h18;
	localparam logic [6:0] ADDR_OUT_MON = 7'h1C;
	localparam logic [6:0] ADDR_TAG_TYPE = 7'h20;
	localparam logic [6:0] ADDR_TAG_VALUE = 7'h24;
	localparam logic [6:0] ADDR_TAG_PACKED = 7'h28;
	localparam logic [6:0] ADDR_SLV_REG = 7'h2C;
	localparam logic [6:0] ADDR_SLV_CFG = 7'h30;
	localparam logic [6:0] ADDR_SLV_ACTIVE = 7'h34;
	localparam logic [6:0] ADDR_SLV_TIMEOUT = 7'h38;
	localparam logic [6:0] ADDR_SLV_RESTART = 7'h3C;
	localparam logic [6:0] ADDR_EPI = 7'h40;
	localparam logic [6:0] ADDR_IRQ_STATUS = 7'h44;
	localparam logic [6:0] ADDR_IRQ_MASK = 7'h48;
	localparam logic [6:0] ADDR_CTRL = 7'h4C;

	// Layout of a test-output status byte.
	localparam int TEST_STATE_W = 4;
	localparam int TEST_OPEN_BIT = 7;

	// Interrupt status and mask bit positions.
	localparam int IRQ_TIMEOUT_BIT = 0;
	localparam int IRQ_FAULT_BIT = 1;
	localparam int IRQ_W = 2;

	// Control register bit: master exchange enable.
	localparam int CTRL_ENABLE_BIT = 0;

	// Reset values.
	localparam logic [15:0] EPI_RESET = 16'h03E8;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

	// Watchdog tick: the interval register counts microseconds.
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// I/O tag data types.
	typedef enum logic [1:0] {
		SIP_TAG_BOOL,
		SIP_TAG_BYTE,
		SIP_TAG_WORD,
		SIP_TAG_DWORD
	} sip_tag_t;

	// Local I/O image sent as remote I/O data.
	typedef struct packed {
		logic [7:0] out_mon;
		logic [4:0][7:0] in_mon;
		logic [7:0] test_hi;
		logic [7:0] test_lo;
	} sip_image_t;

	// Avalon-MM request bundle.
	typedef struct packed {
		logic read;
		logic write;
		logic [6:0] address;
		logic [31:0] writedata;
	} sip_avl_req_t;

endpackage : sip_pkg

// file: hdl/sip_packer_unused.sv
`timescale 1ns/1ns

// file: test/sip_packer_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sip_packer_properties #(
	parameter int NUM_SLAVES = 32,
	parameter bit LARGE_VARIANT = 1'b1,
	parameter int TMO_CYC = 600
) (
	// Clock, reset and bus.
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [6:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Terminals, link and image.
	input wire logic [7:0] test_ok_i,
	input wire logic [1:0] test_open_ok_i,
	input wire logic [39:0] input_eval_i,
	input wire logic [7:0] output_on_i,
	input wire logic [NUM_SLAVES-1:0] slave_rx_i,
	input wire logic [NUM_SLAVES-1:0] slave_active_o,
	input wire logic [NUM_SLAVES-1:0] slave_safe_o,
	input wire sip_pkg::sip_image_t image_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [15:0] quiet;
	// Expected status bytes from the terminal inputs.
	wire logic req = avs_read_i || avs_write_i;
	wire logic [7:0] exp_lo = {test_open_ok_i[0], 3'h0, test_ok_i[3:0]};
	wire logic [7:0] exp_hi = LARGE_VARIANT ? {test_open_ok_i[1], 3'h0, test_ok_i[7:4]} : 8'h00;
	// Counts cycles that slave 0 stays open without a packet.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			quiet <= 16'h0000;
		end else begin
			quiet <= (slave_rx_i[0] || !slave_active_o[0]) ? 16'h0000 : quiet + 16'h0001;
		end
	end
	sequence s_req_new;
		req && avs_waitrequest_o && (!$past(req) || !$past(avs_waitrequest_o));
	endsequence
	sequence s_answer;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	AST_WAIT_ONE: assert property (s_req_new |=> s_answer) else $error("bus wait not one cycle");
	AST_TEST_LO: assert property ($past(rst_b_i) |-> image_o.test_lo == $past(exp_lo)) else $error("test lo");
	AST_TEST_HI: assert property ($past(rst_b_i) |-> image_o.test_hi == $past(exp_hi)) else $error("test hi");
	AST_IN_MON: assert property ($past(rst_b_i) |-> image_o.in_mon == $past(input_eval_i)) else $error("in mon");
	AST_OUT_MON: assert property ($past(rst_b_i) |-> image_o.out_mon == $past(output_on_i)) else $error("out mon");
	AST_SAFE: assert property (slave_safe_o == ~slave_active_o) else $error("safe not inverse");
	AST_QUIET: assert property (quiet < TMO_CYC) else $error("silent slave kept open");
	AST_UNMAPPED: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 7'h4C
		|-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
endmodule : sip_packer_properties
`default_nettype wire

// file: test/sip_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module sip_slave_model #(
	parameter int NUM_SLAVES = 2,
	parameter int PERIOD = 50
) (
	// Clock, reset and control.
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic run_i,
	input wire logic [NUM_SLAVES-1:0] active_i,
	// Packet pulses.
	output logic [NUM_SLAVES-1:0] rx_o
);
	logic [7:0] cnt;
	// Each open slave sends one packet pulse per period while running.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 8'h00;
			rx_o <= '0;
		end else begin
			cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
			rx_o <= (run_i && cnt == 8'h00) ? active_i : '0;
		end
	end
endmodule : sip_slave_model
`default_nettype wire

// file: test/tb_sip_packer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sip_packer;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [6:0] avs_address_i = 7'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o, tag_bytes_o, q;
	logic avs_waitrequest_o, irq_o;
	logic run = 1'b0;
	logic [7:0] test_ok_i = 8'hFF;
	logic [1:0] test_open_ok_i = 2'h3;
	logic [39:0] input_eval_i = 40'h0;
	logic [7:0] output_on_i = 8'h00;
	logic [1:0] slave_rx_i, slave_active_o, slave_safe_o;
	sip_pkg::sip_image_t image_o;
	int n_mismatch = 0;
	int check_count = 0;
	// Clock at 100 MHz.
	always #5 clk_i = ~clk_i;
	sip_packer #(.NUM_SLAVES(2), .LARGE_VARIANT(1'b1)) u_sip_packer (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.test_ok_i(test_ok_i), .test_open_ok_i(test_open_ok_i), .input_eval_i(input_eval_i),
		.output_on_i(output_on_i), .slave_rx_i(slave_rx_i), .slave_active_o(slave_active_o),
		.slave_safe_o(slave_safe_o), .image_o(image_o), .tag_bytes_o(tag_bytes_o), .irq_o(irq_o));
	sip_slave_model #(.NUM_SLAVES(2), .PERIOD(50)) u_sip_slave_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.run_i(run), .active_i(slave_active_o), .rx_o(slave_rx_i));
	// Compares and counts one value.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One bus access, held until waitrequest is seen low.
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !w;
		avs_write_i <= w;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		q = avs_readdata_o;
		chk({31'h0, avs_waitrequest_o}, 32'h0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task rd_chk(input logic [6:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rd_chk
	task t_reset;
		rd_chk(sip_pkg::ADDR_EPI, {16'h0, sip_pkg::EPI_RESET});
		rd_chk(sip_pkg::ADDR_IRQ_MASK, 32'h0);
		rd_chk(sip_pkg::ADDR_CTRL, 32'h0);
		rd_chk(7'h7C, 32'h0);
		chk({30'h0, slave_safe_o}, 32'h3);
	endtask : t_reset
	task automatic t_status;
		logic [7:0] p;
		for (int i = 0; i < 4; i++) begin
			p = (i[0] ? 8'h5A : 8'hA5) ^ (i[1] ? 8'h81 : 8'h00);
			test_ok_i <= p;
			test_open_ok_i <= p[1:0];
			input_eval_i <= {p, ~p, p ^ 8'h3C, ~p ^ 8'h81, p ^ 8'h0F};
			output_on_i <= ~p;
			repeat (2) @(posedge clk_i);
			rd_chk(sip_pkg::ADDR_TEST_LO, {24'h0, p[0], 3'h0, p[3:0]});
			rd_chk(sip_pkg::ADDR_TEST_HI, {24'h0, p[1], 3'h0, p[7:4]});
			for (int m = 0; m < 5; m++)
				rd_chk(sip_pkg::ADDR_IN_MON0 + 7'(4 * m), {24'h0, input_eval_i[8 * m +: 8]});
			rd_chk(sip_pkg::ADDR_OUT_MON, {24'h0, ~p});
		end
	endtask : t_status
	task automatic t_tags;
		logic [31:0] e;
		for (int t = 0; t < 4; t++) begin
			e = (t == 3) ? 32'hFFFFFFFF : (32'h1 << ((t == 0) ? 1 : 8 * t)) - 32'h1;
			bus(1'b1, sip_pkg::ADDR_TAG_TYPE, 32'(t));
			bus(1'b1, sip_pkg::ADDR_TAG_VALUE, 32'hA5C35A81);
			rd_chk(sip_pkg::ADDR_TAG_PACKED, 32'hA5C35A81 & e);
			chk(tag_bytes_o, 32'hA5C35A81 & e);
		end
	endtask : t_tags
	task automatic t_link;
		int n;
		// Clear fault events left over from the status patterns.
		bus(1'b0, sip_pkg::ADDR_IRQ_STATUS, 32'h0);
		bus(1'b1, sip_pkg::ADDR_EPI, 32'h2);
		bus(1'b1, sip_pkg::ADDR_IRQ_MASK, 32'h1);
		bus(1'b1, sip_pkg::ADDR_SLV_REG, 32'h1);
		bus(1'b1, sip_pkg::ADDR_CTRL, 32'h1);
		run <= 1'b1;
		repeat (20) @(posedge clk_i);
		chk({30'h0, slave_active_o}, 32'h0);
		bus(1'b1, sip_pkg::ADDR_SLV_CFG, 32'h1);
		repeat (5) @(posedge clk_i);
		chk({30'h0, slave_active_o}, 32'h1);
		repeat (1000) @(posedge clk_i);
		chk({29'h0, slave_active_o, irq_o}, 32'h2);
		run <= 1'b0;
		n = 0;
		while (slave_active_o[0] !== 1'b0 && n < 600) begin
			@(posedge clk_i);
			n++;
		end
		repeat (3) @(posedge clk_i);
		chk({29'h0, slave_safe_o, irq_o}, 32'h7);
		rd_chk(sip_pkg::ADDR_IRQ_STATUS, 32'h1);
		rd_chk(sip_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		bus(1'b1, sip_pkg::ADDR_SLV_RESTART, 32'h1);
		run <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk({30'h0, slave_active_o}, 32'h1);
	endtask : t_link
	task t_irq;
		test_ok_i <= 8'hFF;
		@(posedge clk_i);
		bus(1'b0, sip_pkg::ADDR_IRQ_STATUS, 32'h0);
		test_ok_i <= 8'hFE;
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		bus(1'b1, sip_pkg::ADDR_IRQ_MASK, 32'h2);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h1);
		rd_chk(sip_pkg::ADDR_IRQ_STATUS, 32'h2);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
	endtask : t_irq
	task final_report;
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report
	// Main sequence after a five-cycle reset.
	initial begin
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		t_reset;
		t_status;
		t_tags;
		t_link;
		t_irq;
		final_report;
	end
	// Watchdog cuts a hang short.
	initial begin
		#300000;
		n_mismatch++;
		final_report;
	end
endmodule : tb_sip_packer
bind sip_packer sip_packer_properties #(.NUM_SLAVES(NUM_SLAVES), .LARGE_VARIANT(LARGE_VARIANT))
	u_sip_packer_properties (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .test_ok_i(test_ok_i), .test_open_ok_i(test_open_ok_i),
	.input_eval_i(input_eval_i), .output_on_i(output_on_i), .slave_rx_i(slave_rx_i),
	.slave_active_o(slave_active_o), .slave_safe_o(slave_safe_o), .image_o(image_o));
`default_nettype wire
